/* File: common/icd_pkg.sv */
// constants, types and decoder shared by the index compare / decimal adjust unit
package icd_pkg;
    localparam logic [7:0] OP_PAGE_SECOND = 8'h18;
    localparam logic [7:0] OP_PAGE_MIXED_Y = 8'h1a;
    localparam logic [7:0] OP_PAGE_MIXED_X = 8'hcd;
    localparam logic [7:0] OP_CMP_IMM = 8'h8c;
    localparam logic [7:0] OP_CMP_DIR = 8'h9c;
    localparam logic [7:0] OP_CMP_EXT = 8'hbc;
    localparam logic [7:0] OP_CMP_IDX = 8'hac;
    localparam logic [7:0] OP_DECIMAL_ADJUST = 8'h19;
    localparam logic [15:0] IDLE_ADDR = 16'hffff;
    localparam logic [7:0] DIRECT_PAGE = 8'h00;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [3:0] BCD_HIGH_ALT = 4'h8;
    localparam logic [3:0] CORR_NIBBLE = 4'h6;

    typedef enum logic [1:0] {MODE_IMM, MODE_DIR, MODE_EXT, MODE_IDX} icd_mode_t;
    typedef enum logic [1:0] {PAGE_NONE, PAGE_SECOND, PAGE_MIXED_Y, PAGE_MIXED_X} icd_page_t;

    typedef struct packed {
        logic valid;
        logic is_adjust;
        logic use_second;
        logic idx_second;
        icd_mode_t mode;
    } icd_dec_t;

    function automatic icd_dec_t icd_decode(input icd_page_t page, input logic [7:0] op);
        icd_dec_t d;
        d = '{valid: 1'b0, is_adjust: 1'b0, use_second: 1'b0, idx_second: 1'b0,
              mode: MODE_IMM};
        case (op)
            OP_CMP_IMM: d.mode = MODE_IMM;
            OP_CMP_DIR: d.mode = MODE_DIR;
            OP_CMP_EXT: d.mode = MODE_EXT;
            default: d.mode = MODE_IDX;
        endcase
        case (page)
            PAGE_NONE:
            begin
                d.valid = (op == OP_CMP_IMM) || (op == OP_CMP_DIR) || (op == OP_CMP_EXT)
                    || (op == OP_CMP_IDX) || (op == OP_DECIMAL_ADJUST);
                d.is_adjust = (op == OP_DECIMAL_ADJUST);
            end
            PAGE_SECOND:
            begin
                d.valid = (op == OP_CMP_IMM) || (op == OP_CMP_DIR) || (op == OP_CMP_EXT)
                    || (op == OP_CMP_IDX);
                d.use_second = 1'b1;
                d.idx_second = 1'b1;
            end
            PAGE_MIXED_Y:
            begin
                d.valid = (op == OP_CMP_IDX);
                d.use_second = 1'b1;
            end
            PAGE_MIXED_X:
            begin
                d.valid = (op == OP_CMP_IDX);
                d.idx_second = 1'b1;
            end
            default: d.valid = 1'b0;
        endcase
        return d;
    endfunction
endpackage

/* File: rtl/icd_exec.sv */
// execution sequencer for the two index compares and the decimal adjust
`timescale 1ns/1ns
module icd_exec
    import icd_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic START,
    input wire logic [15:0] START_PC,
    input wire logic [15:0] INDEX_FIRST,
    input wire logic [15:0] INDEX_SECOND,
    input wire logic [7:0] ACCUMULATOR_ONE,
    input wire logic C_IN,
    input wire logic H_IN,
    input wire logic V_IN,
    input wire logic [7:0] BUS_RDATA,
    output logic [15:0] BUS_ADDR,
    output logic BUS_RW,
    output logic BUSY,
    output logic DONE,
    output logic ILLEGAL,
    output logic [7:0] ACC_OUT,
    output logic N_FLAG,
    output logic Z_FLAG,
    output logic V_FLAG,
    output logic C_FLAG
);
    typedef enum logic [3:0] {
        S_IDLE, S_OPC, S_PRE, S_B1, S_B2, S_DEAD, S_MHI, S_MLO, S_END, S_ADJ
    } icd_state_t;

    icd_state_t state, next_state;
    icd_dec_t dec, next_dec, cur_dec;
    icd_page_t page, next_page;
    logic [15:0] next_addr, eff, next_eff;
    logic [7:0] mhi, next_mhi, mlo, next_mlo, next_acc;
    logic next_done, next_illegal, next_n, next_z, next_v, next_c;
    logic [15:0] cmp_r, cmp_m, base;
    logic [16:0] diff;
    logic lo_fix, hi_fix;
    logic [7:0] corr, adj;

    // every cycle of these sequences is a read
    assign BUS_RW = 1'b1;
    assign BUSY = (state != S_IDLE);

    assign cmp_r = dec.use_second ? INDEX_SECOND : INDEX_FIRST;
    assign cmp_m = {mhi, mlo};
    // subtraction only feeds flags; neither index nor memory is written back
    assign diff = {1'b0, cmp_r} - {1'b0, cmp_m};
    // base comes from the latched decode; the live decode sees the offset byte by then
    assign base = dec.idx_second ? INDEX_SECOND : INDEX_FIRST;

    // high nibble above 8 also needs fixing when a low digit above 9 will carry into it (9 + 1)
    assign lo_fix = H_IN || (ACCUMULATOR_ONE[3:0] > BCD_DIGIT_MAX);
    assign hi_fix = C_IN || (ACCUMULATOR_ONE[7:4] > BCD_DIGIT_MAX)
        || ((ACCUMULATOR_ONE[7:4] > BCD_HIGH_ALT)
        && (ACCUMULATOR_ONE[3:0] > BCD_DIGIT_MAX));
    assign corr = {hi_fix ? CORR_NIBBLE : 4'h0, lo_fix ? CORR_NIBBLE : 4'h0};
    assign adj = ACCUMULATOR_ONE + corr;

    always_comb
    begin
        next_state = state;
        next_addr = BUS_ADDR;
        next_dec = dec;
        next_page = page;
        next_eff = eff;
        next_mhi = mhi;
        next_mlo = mlo;
        next_acc = ACC_OUT;
        next_done = 1'b0;
        next_illegal = 1'b0;
        next_n = N_FLAG;
        next_z = Z_FLAG;
        next_v = V_FLAG;
        next_c = C_FLAG;
        cur_dec = icd_decode(page, BUS_RDATA);
        case (state)
            S_IDLE:
            begin
                next_page = PAGE_NONE;
                if (START)
                begin
                    next_state = S_OPC;
                    next_addr = START_PC;
                end
            end
            S_OPC, S_PRE:
            begin
                next_dec = cur_dec;
                next_addr = BUS_ADDR + 16'h0001;
                if (state == S_OPC && BUS_RDATA == OP_PAGE_SECOND)
                begin
                    next_page = PAGE_SECOND;
                    next_state = S_PRE;
                end
                else if (state == S_OPC && BUS_RDATA == OP_PAGE_MIXED_Y)
                begin
                    next_page = PAGE_MIXED_Y;
                    next_state = S_PRE;
                end
                else if (state == S_OPC && BUS_RDATA == OP_PAGE_MIXED_X)
                begin
                    next_page = PAGE_MIXED_X;
                    next_state = S_PRE;
                end
                else if (!cur_dec.valid)
                begin
                    next_illegal = 1'b1;
                    next_state = S_IDLE;
                    next_addr = IDLE_ADDR;
                end
                else if (cur_dec.is_adjust)
                    next_state = S_ADJ;
                else if (cur_dec.mode == MODE_IMM)
                    next_state = S_MHI;
                else
                    next_state = S_B1;
            end
            S_B1:
            begin
                case (dec.mode)
                    MODE_DIR:
                    begin
                        next_eff = {DIRECT_PAGE, BUS_RDATA};
                        next_addr = {DIRECT_PAGE, BUS_RDATA};
                        next_state = S_MHI;
                    end
                    MODE_EXT:
                    begin
                        next_mhi = BUS_RDATA;
                        next_addr = BUS_ADDR + 16'h0001;
                        next_state = S_B2;
                    end
                    default:
                    begin
                        next_eff = base + {8'h00, BUS_RDATA};
                        next_addr = IDLE_ADDR;
                        next_state = S_DEAD;
                    end
                endcase
            end
            S_B2:
            begin
                next_addr = {mhi, BUS_RDATA};
                next_state = S_MHI;
            end
            S_DEAD:
            begin
                next_addr = eff;
                next_state = S_MHI;
            end
            S_MHI:
            begin
                next_mhi = BUS_RDATA;
                next_addr = BUS_ADDR + 16'h0001;
                next_state = S_MLO;
            end
            S_MLO:
            begin
                next_mlo = BUS_RDATA;
                next_addr = IDLE_ADDR;
                next_state = S_END;
            end
            S_END:
            begin
                next_n = diff[15];
                next_z = (diff[15:0] == 16'h0000);
                next_v = (cmp_r[15] && !cmp_m[15] && !diff[15])
                    || (!cmp_r[15] && cmp_m[15] && diff[15]);
                next_c = diff[16];
                next_done = 1'b1;
                next_state = S_IDLE;
            end
            S_ADJ:
            begin
                next_acc = adj;
                next_c = hi_fix;
                next_n = adj[7];
                next_z = (adj == 8'h00);
                // overflow is undefined here; the incoming value is kept
                next_v = V_IN;
                next_done = 1'b1;
                next_addr = IDLE_ADDR;
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state <= S_IDLE;
            BUS_ADDR <= IDLE_ADDR;
            dec <= '0;
            page <= PAGE_NONE;
            eff <= 16'h0000;
            mhi <= 8'h00;
            mlo <= 8'h00;
            ACC_OUT <= 8'h00;
            DONE <= 1'b0;
            ILLEGAL <= 1'b0;
            N_FLAG <= 1'b0;
            Z_FLAG <= 1'b0;
            V_FLAG <= 1'b0;
            C_FLAG <= 1'b0;
        end
        else
        begin
            state <= next_state;
            BUS_ADDR <= next_addr;
            dec <= next_dec;
            page <= next_page;
            eff <= next_eff;
            mhi <= next_mhi;
            mlo <= next_mlo;
            ACC_OUT <= next_acc;
            DONE <= next_done;
            ILLEGAL <= next_illegal;
            N_FLAG <= next_n;
            Z_FLAG <= next_z;
            V_FLAG <= next_v;
            C_FLAG <= next_c;
        end
    end

    property p_cmp_zero;
        @(posedge CLK) disable iff (!RESETN)
        (state == S_END) |=> (Z_FLAG == $past(cmp_r == cmp_m));
    endproperty
    a_cmp_zero: assert property (p_cmp_zero) else $error("compare zero flag wrong");

    property p_cmp_neg;
        @(posedge CLK) disable iff (!RESETN)
        (state == S_END) |=> (N_FLAG == $past(cmp_r[15] ^ cmp_m[15] ^ (cmp_r < cmp_m)
            ^ ((cmp_r[14:0] < cmp_m[14:0]) ^ (cmp_r < cmp_m))));
    endproperty
    a_cmp_neg: assert property (p_cmp_neg) else $error("compare negative flag wrong");

    property p_cmp_ovf;
        @(posedge CLK) disable iff (!RESETN)
        (state == S_END) |=> (V_FLAG == $past((cmp_r[15] != cmp_m[15])
            && (cmp_r[15] != diff[15])));
    endproperty
    a_cmp_ovf: assert property (p_cmp_ovf) else $error("compare overflow flag wrong");

    property p_cmp_borrow;
        @(posedge CLK) disable iff (!RESETN)
        (state == S_END) |=> (C_FLAG == $past(cmp_r < cmp_m));
    endproperty
    a_cmp_borrow: assert property (p_cmp_borrow) else $error("compare borrow wrong");

    property p_word_order;
        @(posedge CLK) disable iff (!RESETN)
        (state == S_MHI) |=> (BUS_ADDR == $past(BUS_ADDR) + 16'h0001) ##1 (BUS_ADDR == IDLE_ADDR);
    endproperty
    a_word_order: assert property (p_word_order) else $error("operand word order wrong");

    property p_first_imm_len;
        @(posedge CLK) disable iff (!RESETN)
        (state == S_OPC && BUS_RDATA == OP_CMP_IMM) |-> !DONE [*4] ##1 DONE;
    endproperty
    a_first_imm_len: assert property (p_first_imm_len)
        else $error("immediate length wrong");

    property p_second_ext_len;
        @(posedge CLK) disable iff (!RESETN)
        (state == S_OPC && BUS_RDATA == OP_PAGE_SECOND) ##1 (BUS_RDATA == OP_CMP_EXT)
        |-> ##6 DONE;
    endproperty
    a_second_ext_len: assert property (p_second_ext_len)
        else $error("extended length wrong");

    property p_adjust_carry;
        @(posedge CLK) disable iff (!RESETN)
        (state == S_ADJ) |=> (C_FLAG == ($past(C_IN)
            || ($past(ACCUMULATOR_ONE) > {BCD_DIGIT_MAX, BCD_DIGIT_MAX})));
    endproperty
    a_adjust_carry: assert property (p_adjust_carry)
        else $error("adjust carry wrong");

    property p_adjust_nz;
        @(posedge CLK) disable iff (!RESETN)
        (state == S_ADJ) |=> (N_FLAG == ACC_OUT[7]) && (Z_FLAG == (ACC_OUT == 8'h00));
    endproperty
    a_adjust_nz: assert property (p_adjust_nz) else $error("adjust N or Z wrong");

    property p_adjust_len;
        @(posedge CLK) disable iff (!RESETN)
        (state == S_OPC && BUS_RDATA == OP_DECIMAL_ADJUST && page == PAGE_NONE)
        |=> (BUS_ADDR == $past(BUS_ADDR) + 16'h0001) ##1 DONE;
    endproperty
    a_adjust_len: assert property (p_adjust_len)
        else $error("adjust sequence wrong");

    c_first_idx: cover property (@(posedge CLK) disable iff (!RESETN)
        (state == S_OPC && BUS_RDATA == OP_CMP_IDX) ##6 DONE);
    c_mixed: cover property (@(posedge CLK) disable iff (!RESETN)
        (state == S_PRE && page == PAGE_MIXED_Y) ##6 DONE);
    c_adjust_66: cover property (@(posedge CLK) disable iff (!RESETN)
        (state == S_ADJ && corr == 8'h66));
    c_illegal: cover property (@(posedge CLK) disable iff (!RESETN) ILLEGAL);
endmodule // icd_exec

/* File: sim/icd_mem_model.sv */
// behavioural memory answering the unit's read cycles
`timescale 1ns/1ns
module icd_mem_model
(
    input wire logic clk,
    input wire logic [15:0] addr,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] junk = 8'h00;
    initial
    begin
        for (int a = 0; a < 65536; a++)
        begin
            mem[a] = a[7:0] ^ 8'h3c;
        end
    end
    // the idle slot carries no data, so its value moves every cycle
    always @(posedge clk)
    begin
        junk <= junk + 8'h35;
    end
    assign rdata = (addr == 16'hffff) ? junk : mem[addr];
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        mem[a] = d;
    endtask
endmodule // icd_mem_model

/* File: sim/tb_top.sv */
// self-checking bench for the index compare and decimal adjust unit
`timescale 1ns/1ns
module tb_top;
    import icd_pkg::*;
    typedef struct {
        logic [7:0] pre;
        logic [7:0] op;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] w;
        logic c;
        logic h;
        logic [7:0] res;
        logic rc;
        int cyc;
        logic bad;
    } icd_row_t;
    localparam int NR = 23;
    // adjust rows only use states a bcd add can leave behind
    icd_row_t rows [NR] = '{
        '{8'h00, 8'h8c, 16'h1234, 16'h0000, 16'h1234, 1'h0, 1'h0, 8'h00, 1'h0, 4, 1'h0},
        '{8'h00, 8'h9c, 16'h8000, 16'h0000, 16'h0001, 1'h0, 1'h0, 8'h00, 1'h0, 5, 1'h0},
        '{8'h00, 8'hbc, 16'h0001, 16'h0000, 16'h0002, 1'h0, 1'h0, 8'h00, 1'h0, 6, 1'h0},
        '{8'h00, 8'hac, 16'h1000, 16'h0000, 16'h0ff0, 1'h0, 1'h0, 8'h00, 1'h0, 6, 1'h0},
        '{8'hcd, 8'hac, 16'h7fff, 16'h2000, 16'hffff, 1'h0, 1'h0, 8'h00, 1'h0, 7, 1'h0},
        '{8'h18, 8'h8c, 16'h0000, 16'h0000, 16'h0000, 1'h0, 1'h0, 8'h00, 1'h0, 5, 1'h0},
        '{8'h18, 8'h9c, 16'h0000, 16'h5555, 16'haaaa, 1'h0, 1'h0, 8'h00, 1'h0, 6, 1'h0},
        '{8'h18, 8'hbc, 16'h0000, 16'hffff, 16'h0001, 1'h0, 1'h0, 8'h00, 1'h0, 7, 1'h0},
        '{8'h18, 8'hac, 16'h0000, 16'h3000, 16'h3000, 1'h0, 1'h0, 8'h00, 1'h0, 7, 1'h0},
        '{8'h1a, 8'hac, 16'h1800, 16'h8001, 16'h7fff, 1'h0, 1'h0, 8'h00, 1'h0, 7, 1'h0},
        '{8'h00, 8'h19, 16'h0000, 16'h0000, 16'h0045, 1'h0, 1'h0, 8'h45, 1'h0, 2, 1'h0},
        '{8'h00, 8'h19, 16'h0000, 16'h0000, 16'h004b, 1'h0, 1'h0, 8'h51, 1'h0, 2, 1'h0},
        '{8'h00, 8'h19, 16'h0000, 16'h0000, 16'h0042, 1'h0, 1'h1, 8'h48, 1'h0, 2, 1'h0},
        '{8'h00, 8'h19, 16'h0000, 16'h0000, 16'h00a5, 1'h0, 1'h0, 8'h05, 1'h1, 2, 1'h0},
        '{8'h00, 8'h19, 16'h0000, 16'h0000, 16'h009b, 1'h0, 1'h0, 8'h01, 1'h1, 2, 1'h0},
        '{8'h00, 8'h19, 16'h0000, 16'h0000, 16'h00b2, 1'h0, 1'h1, 8'h18, 1'h1, 2, 1'h0},
        '{8'h00, 8'h19, 16'h0000, 16'h0000, 16'h0025, 1'h1, 1'h0, 8'h85, 1'h1, 2, 1'h0},
        '{8'h00, 8'h19, 16'h0000, 16'h0000, 16'h002c, 1'h1, 1'h0, 8'h92, 1'h1, 2, 1'h0},
        '{8'h00, 8'h19, 16'h0000, 16'h0000, 16'h0033, 1'h1, 1'h1, 8'h99, 1'h1, 2, 1'h0},
        '{8'h00, 8'h19, 16'h0000, 16'h0000, 16'h009a, 1'h0, 1'h0, 8'h00, 1'h1, 2, 1'h0},
        '{8'h00, 8'h8d, 16'h0000, 16'h0000, 16'h0000, 1'h0, 1'h0, 8'h00, 1'h0, 1, 1'h1},
        '{8'h18, 8'h19, 16'h0000, 16'h0000, 16'h0000, 1'h0, 1'h0, 8'h00, 1'h0, 2, 1'h1},
        '{8'hcd, 8'h8c, 16'h0000, 16'h0000, 16'h0000, 1'h0, 1'h0, 8'h00, 1'h0, 2, 1'h1}};
    logic clk, resetn, start, c_in, h_in, v_in, bus_rw, busy, done, illegal;
    logic n_flag, z_flag, v_flag, c_flag, chained;
    logic [15:0] start_pc, index_first, index_second, bus_addr, p;
    logic [7:0] accumulator_one, bus_rdata, acc_out;
    logic [3:0] prev;
    icd_row_t r;
    int k;
    int n_errors = 0;
    int check_count = 0;
    icd_exec uut (.CLK(clk), .RESETN(resetn), .START(start), .START_PC(start_pc),
        .INDEX_FIRST(index_first), .INDEX_SECOND(index_second),
        .ACCUMULATOR_ONE(accumulator_one), .C_IN(c_in), .H_IN(h_in), .V_IN(v_in),
        .BUS_RDATA(bus_rdata), .BUS_ADDR(bus_addr), .BUS_RW(bus_rw), .BUSY(busy),
        .DONE(done), .ILLEGAL(illegal), .ACC_OUT(acc_out), .N_FLAG(n_flag),
        .Z_FLAG(z_flag), .V_FLAG(v_flag), .C_FLAG(c_flag));
    icd_mem_model mem (.clk(clk), .addr(bus_addr), .rdata(bus_rdata));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [3:0] nzvc(input logic [15:0] a, input logic [15:0] m);
        logic [15:0] d;
        d = a - m;
        return {d[15], d == 16'h0000, (a[15] & ~m[15] & ~d[15]) | (~a[15] & m[15] & d[15]),
            (~a[15] & m[15]) | (m[15] & d[15]) | (d[15] & ~a[15])};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        if (n_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic reset_check();
        @(negedge clk);
        check("idle state", {bus_addr, busy, done, illegal, acc_out, n_flag, z_flag, v_flag,
            c_flag, bus_rw}, {16'hffff, 3'h0, 8'h00, 4'h0, 1'h1});
    endtask
    task automatic load(input icd_row_t t, input logic [15:0] a);
        logic [15:0] q;
        logic [15:0] m;
        q = a;
        if (t.pre != 8'h00)
        begin
            mem.put(q, t.pre);
            q++;
        end
        mem.put(q, t.op);
        m = q + 16'h0001;
        case (t.op)
            8'h9c: m = 16'h0040;
            8'hbc: m = 16'h3456;
            8'hac: m = ((t.pre == 8'h18 || t.pre == 8'hcd) ? t.y : t.x) + 16'h0010;
            default: ;
        endcase
        if (t.op == 8'hbc)
        begin
            mem.put(q + 16'h0001, 8'h34);
            mem.put(q + 16'h0002, 8'h56);
        end
        else if (t.op != 8'h8c)
            mem.put(q + 16'h0001, m[7:0]);
        // high byte first, low byte at the next address
        mem.put(m, t.w[15:8]);
        mem.put(m + 16'h0001, t.w[7:0]);
    endtask
    task automatic launch(input icd_row_t t, input logic [15:0] a);
        start <= 1'h1;
        start_pc <= a;
        index_first <= t.x;
        index_second <= t.y;
        accumulator_one <= t.w[7:0];
        c_in <= t.c;
        h_in <= t.h;
        v_in <= t.op[0];
    endtask
    initial
    begin
        {start, start_pc, index_first, index_second, accumulator_one, c_in, h_in, v_in} = '0;
        resetn = 1'b0;
        repeat (12) @(posedge clk);
        reset_check();
        @(posedge clk);
        resetn <= 1'h1;
        load(rows[0], 16'h4000);
        @(posedge clk);
        launch(rows[0], 16'h4000);
        for (int i = 0; i < NR; i++)
        begin
            r = rows[i];
            p = 16'h4000 + 16'(i * 8);
            chained = 1'b0;
            @(posedge clk);
            start <= 1'h0;
            for (k = 0; k < 12; k++)
            begin
                @(negedge clk);
                check("read only", bus_rw, 1'h1);
                check("busy", busy, k < r.cyc);
                if (k == 0)
                    check("opcode address", bus_addr, p);
                if (k == 1 && !r.bad)
                    check("second fetch", bus_addr, p + 16'h0001);
                if (done === 1'h1 || illegal === 1'h1)
                    break;
                // a start while busy must be dropped along with its address
                if (i == 2 && k < 2)
                begin
                    @(posedge clk);
                    start <= (k == 0);
                    start_pc <= 16'h0000;
                end
                if (k == r.cyc - 1 && !r.bad)
                begin
                    if (r.op != 8'h19)
                        check("idle address", bus_addr, 16'hffff);
                    if (i + 1 < NR)
                    begin
                        load(rows[i + 1], p + 16'h0008);
                        @(posedge clk);
                        launch(rows[i + 1], p + 16'h0008);
                        chained = 1'b1;
                    end
                end
            end
            if (k == 12)
            begin
                n_errors++;
                break;
            end
            check("cycle count", k, r.cyc);
            check("illegal pulse", illegal, r.bad);
            if (r.bad)
                check("flags kept", {n_flag, z_flag, v_flag, c_flag}, prev);
            else if (r.op == 8'h19)
            begin
                check("adjusted value", acc_out, r.res);
                check("adjust carry", c_flag, r.rc);
                check("adjust nz", {n_flag, z_flag}, {r.res[7], r.res == 8'h00});
                check("adjust overflow kept", v_flag, r.op[0]);
            end
            else
                check("compare flags", {n_flag, z_flag, v_flag, c_flag},
                    nzvc((r.pre == 8'h18 || r.pre == 8'h1a) ? r.y : r.x, r.w));
            prev = {n_flag, z_flag, v_flag, c_flag};
            if (!chained && i + 1 < NR)
            begin
                load(rows[i + 1], p + 16'h0008);
                @(posedge clk);
                launch(rows[i + 1], p + 16'h0008);
            end
        end
        @(posedge clk);
        launch(rows[2], 16'h4010);
        @(posedge clk);
        start <= 1'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'h0;
        reset_check();
        @(posedge clk);
        resetn <= 1'h1;
        repeat (2) @(posedge clk);
        reset_check();
        test_done();
    end
endmodule // tb_top
